// ===== design/hseq_defs.svh
`ifndef HSEQ_DEFS_SVH
`define HSEQ_DEFS_SVH
// ----------------------------------------
// Method codes
// ----------------------------------------
`define HSEQ_METHOD_MAX 6'h23
`define HSEQ_M_NONE 6'h00
`define HSEQ_M_RSV15 6'h0f
`define HSEQ_M_RSV16 6'h10
`define HSEQ_M_RSV31 6'h1f
`define HSEQ_M_RSV32 6'h20
`define HSEQ_M_IDX_NEG 6'h21
`define HSEQ_M_IDX_POS 6'h22
`define HSEQ_M_SET_POS 6'h23
`define HSEQ_M_NOIDX_OFS 6'h10
// ----------------------------------------
// Widths and profile
// ----------------------------------------
`define HSEQ_POS_W 32
`define HSEQ_SPD_W 32
`define HSEQ_ACC_W 32
`define HSEQ_TICK_DIV 16'h007d
`endif

// ===== design/hseq_pkg.sv
package hseq_pkg;
  typedef enum logic [3:0] {
    HSEQ_IDLE = 4'b0000,
    HSEQ_SEEK = 4'b0001,
    HSEQ_LEAVE = 4'b0010,
    HSEQ_ZERO = 4'b0011,
    HSEQ_STOP = 4'b0100,
    HSEQ_DONE = 4'b0101,
    HSEQ_ERR = 4'b0110
  } hseq_state_e;
  typedef logic [5:0] hseq_method_t;
endpackage : hseq_pkg

// ===== design/hseq_ramp.sv
`timescale 1ns/100ps
`include "hseq_defs.svh"
// Velocity ramp: one acceleration value for speed-up and slow-down
module hseq_ramp #(
  parameter int SPD_W = `HSEQ_SPD_W
) (
  // Clock and reset
  input wire logic core_clk_in,
  input wire logic rst_b_in,
  // Control
  input wire logic tick_in,
  input wire logic [SPD_W-1:0] target_in,
  input wire logic [SPD_W-1:0] accel_in,
  // Result
  output logic [SPD_W-1:0] speed_out,
  output logic at_zero_out
);
  logic [SPD_W-1:0] spd_q;
  logic [SPD_W-1:0] spd_d;
  wire logic up = spd_q < target_in;
  wire logic [SPD_W-1:0] gap = up ? target_in - spd_q : spd_q - target_in;
  wire logic [SPD_W-1:0] step = (gap < accel_in) ? gap : accel_in;
  // Same step size in both directions
  assign spd_d = !tick_in ? spd_q : (up ? spd_q + step : spd_q - step);
  always_ff @(posedge core_clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
      spd_q <= '0;
    else
      spd_q <= spd_d;
  end
  assign speed_out = spd_q;
  assign at_zero_out = spd_q == '0;
  a_ramp_step: assert property (@(posedge core_clk_in) disable iff (!rst_b_in)
    tick_in |=> (spd_q - $past(spd_q) <= $past(accel_in))
             || ($past(spd_q) - spd_q <= $past(accel_in)))
    else $error("ramp step larger than acceleration");
endmodule : hseq_ramp

// ===== design/hseq_top.sv
`timescale 1ns/100ps
`include "hseq_defs.svh"
module hseq_top
  import hseq_pkg::*;
#(
  parameter int POS_W = `HSEQ_POS_W,
  parameter int SPD_W = `HSEQ_SPD_W,
  parameter logic [15:0] TICK_DIV = `HSEQ_TICK_DIV
) (
  // Clock and reset
  input wire logic core_clk_in,
  input wire logic rst_b_in,
  // Configuration
  input wire logic [SPD_W-1:0] switch_speed_in,
  input wire logic [SPD_W-1:0] zero_speed_in,
  input wire hseq_pkg::hseq_method_t method_in,
  input wire logic [SPD_W-1:0] accel_in,
  input wire logic [POS_W-1:0] home_pos_in,
  // Control
  input wire logic start_in,
  input wire logic pos_step_in,
  // Sensors (asynchronous pins)
  input wire logic index_in,
  input wire logic home_sw_in,
  input wire logic pos_limit_in,
  input wire logic neg_limit_in,
  // Motion and status
  output logic [SPD_W-1:0] speed_out,
  output logic dir_pos_out,
  output logic [POS_W-1:0] position_out,
  output logic busy_out,
  output logic done_out,
  output logic error_out
);
  // ----------------------------------------
  // Reset and pin synchronisers
  // ----------------------------------------
  logic [1:0] rst_sync_q;
  logic rst_b;
  logic [3:0] pin_s1_q;
  logic [3:0] pin_s2_q;
  logic [3:0] pin_s3_q;
  always_ff @(posedge core_clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
      rst_sync_q <= 2'b00;
    else
      rst_sync_q <= {rst_sync_q[0], 1'b1};
  end
  assign rst_b = rst_sync_q[1];
  always_ff @(posedge core_clk_in or negedge rst_b)
  begin
    if (!rst_b)
    begin
      pin_s1_q <= 4'h0;
      pin_s2_q <= 4'h0;
      pin_s3_q <= 4'h0;
    end
    else
    begin
      pin_s1_q <= {neg_limit_in, pos_limit_in, home_sw_in, index_in};
      pin_s2_q <= pin_s1_q;
      pin_s3_q <= pin_s2_q;
    end
  end
  wire logic index_rise = pin_s2_q[0] & ~pin_s3_q[0];
  wire logic home_lvl = pin_s2_q[1];
  wire logic home_chg = pin_s2_q[1] ^ pin_s3_q[1];
  wire logic plim_lvl = pin_s2_q[2];
  wire logic plim_chg = pin_s2_q[2] ^ pin_s3_q[2];
  wire logic nlim_lvl = pin_s2_q[3];
  wire logic nlim_chg = pin_s2_q[3] ^ pin_s3_q[3];

  // ----------------------------------------
  // Method decode
  // ----------------------------------------
  function automatic logic is_reserved(input hseq_method_t m);
    is_reserved = (m == `HSEQ_M_NONE) || (m > `HSEQ_METHOD_MAX)
      || (m == `HSEQ_M_RSV15) || (m == `HSEQ_M_RSV16)
      || (m == `HSEQ_M_RSV31) || (m == `HSEQ_M_RSV32);
  endfunction : is_reserved
  hseq_method_t meth_q;
  // Methods 17-30 map onto 1-14 without the index
  wire logic no_index = (meth_q > `HSEQ_M_RSV16) && (meth_q < `HSEQ_M_RSV31);
  wire hseq_method_t base = no_index ? meth_q - `HSEQ_M_NOIDX_OFS : meth_q;
  wire logic grp_lim = base <= 6'h02;
  wire logic grp_home = (base >= 6'h03) && (base <= 6'h06);
  wire logic grp_full = (base >= 6'h07) && (base <= 6'h0e);
  wire logic grp_idx = (meth_q == `HSEQ_M_IDX_NEG) || (meth_q == `HSEQ_M_IDX_POS);
  wire logic grp_set = meth_q == `HSEQ_M_SET_POS;
  // Methods 3/4 use positive home switch, 5/6 mirror on negative side
  wire logic home_neg_side = (base == 6'h05) || (base == 6'h06);
  wire logic odd_home = base[0];
  // Home switch polarity: 3, 6 and 7-14 active high, 4 and 5 active low
  wire logic home_pol = (base == 6'h03) || (base == 6'h06) || grp_full;
  wire logic home_act = home_lvl ~^ home_pol;
  wire logic full_pos_lim = base <= 6'h0a;
  wire logic full_left_edge = (base == 6'h07) || (base == 6'h08) || (base == 6'h0b)
    || (base == 6'h0c);
  // Odd member takes the index on the far side of the edge
  wire logic full_index_past = base[0];
  // Only the limit becoming active reverses; its release on the way back is ignored
  wire logic full_lim_chg = full_pos_lim ? (plim_chg & plim_lvl) : (nlim_chg & nlim_lvl);

  // ----------------------------------------
  // Sequencer
  // ----------------------------------------
  hseq_state_e state_q;
  hseq_state_e state_d;
  logic dir_q;
  logic dir_d;
  logic [SPD_W-1:0] target;
  logic [SPD_W-1:0] ramp_speed;
  logic ramp_zero;
  logic [POS_W-1:0] pos_q;
  logic [15:0] div_q;
  wire logic tick = div_q == 16'h0000;
  // Start is ignored in every moving state, the final slow-down included
  wire logic active = (state_q == HSEQ_SEEK) || (state_q == HSEQ_LEAVE)
    || (state_q == HSEQ_ZERO) || (state_q == HSEQ_STOP);
  // Event ending the switch search in the current method
  wire logic seek_evt = grp_lim ? (base == 6'h01 ? nlim_chg : plim_chg)
    : grp_home ? home_chg
    : grp_full ? (home_chg | full_lim_chg)
    : index_rise;
  wire logic zero_evt = no_index ? 1'b1 : index_rise;
  // Start direction per group
  wire logic start_dir = grp_lim ? (base == 6'h02)
    : grp_home ? (home_act ^ home_neg_side ^ odd_home)
    : grp_full ? (home_act ? ~full_left_edge : full_pos_lim)
    : (meth_q == `HSEQ_M_IDX_POS);

  always_comb
  begin
    state_d = state_q;
    dir_d = dir_q;
    case (state_q)
      HSEQ_IDLE, HSEQ_DONE, HSEQ_ERR:
      begin
        if (start_in)
        begin
          if (is_reserved(method_in))
            state_d = HSEQ_ERR;
          else
            state_d = HSEQ_LEAVE;
        end
      end
      HSEQ_LEAVE:
      begin
        // One cycle to latch the method and pick a direction
        dir_d = start_dir;
        state_d = grp_set ? HSEQ_DONE : HSEQ_SEEK;
      end
      HSEQ_SEEK:
      begin
        if (seek_evt)
        begin
          if (grp_idx)
            state_d = HSEQ_STOP;
          else
          begin
            // Final approach runs back over the found edge; odd full-search members carry on past it
            dir_d = (grp_full && full_lim_chg) ? dir_q : ~dir_q;
            state_d = (grp_full && full_lim_chg) ? HSEQ_SEEK : HSEQ_ZERO;
            if (grp_full && full_lim_chg)
              dir_d = ~dir_q;
            if (grp_full && !full_lim_chg && full_index_past)
              dir_d = dir_q;
          end
        end
      end
      HSEQ_ZERO:
      begin
        if (zero_evt)
          state_d = HSEQ_STOP;
      end
      HSEQ_STOP:
      begin
        if (ramp_zero)
          state_d = HSEQ_DONE;
      end
      default:
        state_d = HSEQ_IDLE;
    endcase
  end

  // Switch search fast, zero search slow, halt otherwise
  assign target = (state_q == HSEQ_SEEK) ? (grp_idx ? zero_speed_in : switch_speed_in)
    : (state_q == HSEQ_ZERO) ? zero_speed_in : '0;

  always_ff @(posedge core_clk_in or negedge rst_b)
  begin
    if (!rst_b)
    begin
      state_q <= HSEQ_IDLE;
      dir_q <= 1'b1;
      meth_q <= 6'h00;
      div_q <= 16'h0000;
    end
    else
    begin
      state_q <= state_d;
      dir_q <= dir_d;
      div_q <= tick ? TICK_DIV : div_q - 16'h0001;
      if (start_in && !active)
        meth_q <= method_in;
    end
  end

  // Position counter: loaded with home value on completion
  always_ff @(posedge core_clk_in or negedge rst_b)
  begin
    if (!rst_b)
      pos_q <= '0;
    else if (state_d == HSEQ_DONE && state_q != HSEQ_DONE)
      pos_q <= home_pos_in;
    else if (pos_step_in)
      pos_q <= dir_q ? pos_q + 1'b1 : pos_q - 1'b1;
  end

  hseq_ramp #(
    .SPD_W(SPD_W)
  ) u_ramp (
    .core_clk_in(core_clk_in),
    .rst_b_in(rst_b),
    .tick_in(tick),
    .target_in(target),
    .accel_in(accel_in),
    .speed_out(ramp_speed),
    .at_zero_out(ramp_zero)
  );

  assign speed_out = ramp_speed;
  assign dir_pos_out = dir_q;
  assign position_out = pos_q;
  assign busy_out = state_q != HSEQ_IDLE && state_q != HSEQ_DONE && state_q != HSEQ_ERR;
  assign done_out = state_q == HSEQ_DONE;
  assign error_out = state_q == HSEQ_ERR;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  a_reserved_refused: assert property (@(posedge core_clk_in) disable iff (!rst_b)
    (!active && start_in && is_reserved(method_in)) |=> error_out && ramp_zero)
    else $error("reserved method not refused");
  a_done_loads_pos: assert property (@(posedge core_clk_in) disable iff (!rst_b)
    $rose(done_out) |-> position_out == $past(home_pos_in))
    else $error("home position not loaded");
  a_done_stopped: assert property (@(posedge core_clk_in) disable iff (!rst_b)
    done_out |-> speed_out == '0)
    else $error("motion while done");
  a_set_no_motion: assert property (@(posedge core_clk_in) disable iff (!rst_b)
    (state_q == HSEQ_LEAVE && grp_set) |=> done_out ##0 speed_out == '0)
    else $error("method 35 moved");
  a_idx_dir: assert property (@(posedge core_clk_in) disable iff (!rst_b)
    (state_q == HSEQ_LEAVE && grp_idx) |=> dir_pos_out == (meth_q == `HSEQ_M_IDX_POS))
    else $error("index method direction wrong");
  a_lim_dir: assert property (@(posedge core_clk_in) disable iff (!rst_b)
    (state_q == HSEQ_LEAVE && meth_q == 6'h01) |=> !dir_pos_out)
    else $error("method 1 not negative");
  a_lim_reverse: assert property (@(posedge core_clk_in) disable iff (!rst_b)
    (state_q == HSEQ_SEEK && grp_lim && seek_evt) |=> dir_pos_out != $past(dir_pos_out))
    else $error("no reversal on limit");
  a_zero_index: assert property (@(posedge core_clk_in) disable iff (!rst_b)
    (state_q == HSEQ_ZERO && no_index) |=> state_q == HSEQ_STOP)
    else $error("index used without index");
  a_busy_ignored: assert property (@(posedge core_clk_in) disable iff (!rst_b)
    (active && start_in) |=> $stable(meth_q))
    else $error("start taken while busy");
  a_full_lim_rev: assert property (@(posedge core_clk_in) disable iff (!rst_b)
    (state_q == HSEQ_SEEK && grp_full && full_lim_chg)
      |=> state_q == HSEQ_SEEK && dir_pos_out != $past(dir_pos_out))
    else $error("limit did not reverse search");
  a_error_still: assert property (@(posedge core_clk_in) disable iff (!rst_b)
    error_out |-> speed_out == '0 && !busy_out)
    else $error("motion after refused start");
  c_full_lim: cover property (@(posedge core_clk_in)
    state_q == HSEQ_SEEK && grp_full && full_lim_chg);
  c_done: cover property (@(posedge core_clk_in) $rose(done_out));
  c_error: cover property (@(posedge core_clk_in) $rose(error_out));
  c_zero: cover property (@(posedge core_clk_in) state_q == HSEQ_ZERO);
endmodule : hseq_top

// ===== dv/hseq_motor_model.sv
`timescale 1ns/100ps
// Motor with encoder, index every 16 counts, home region and two limits
module hseq_motor_model (
  // Clock and reset
  input wire logic core_clk_in,
  input wire logic rst_b_in,
  // Drive side
  input wire logic [31:0] speed_in,
  input wire logic dir_pos_in,
  input wire logic place_in,
  // Feedback
  output logic step_out,
  output logic index_out,
  output logic home_sw_out,
  output logic pos_limit_out,
  output logic neg_limit_out
);
  int pos_q;
  int acc_q;
  int acc_d;
  // ----------------------------------------
  // Travel: one count per 1000 units of speed
  // ----------------------------------------
  assign acc_d = acc_q + int'(speed_in);
  always_ff @(posedge core_clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      pos_q <= 0;
      acc_q <= 0;
      step_out <= 1'b0;
    end
    else if (place_in)
    begin
      pos_q <= 0;
      acc_q <= 0;
      step_out <= 1'b0;
    end
    else
    begin
      step_out <= acc_d >= 1000;
      acc_q <= (acc_d >= 1000) ? acc_d - 1000 : acc_d;
      if (acc_d >= 1000)
        pos_q <= dir_pos_in ? pos_q + 1 : pos_q - 1;
    end
  end
  // ----------------------------------------
  // Sensors follow the physical position
  // ----------------------------------------
  assign index_out = (((pos_q % 16) + 16) % 16) == 0;
  assign home_sw_out = (pos_q >= 40) && (pos_q < 80);
  assign pos_limit_out = pos_q >= 120;
  assign neg_limit_out = pos_q <= -120;
endmodule : hseq_motor_model

// ===== dv/hseq_tb_top.sv
`timescale 1ns/100ps
module hseq_tb_top;
  localparam logic [31:0] SW_SPD = 32'h0000_01f4;
  localparam logic [31:0] ZR_SPD = 32'h0000_00c8;
  localparam logic [31:0] ACC = 32'h0000_0032;
  logic clk, rst_b, start, place, step, idx, home, plim, nlim;
  logic dir_pos, busy, done, error;
  logic [31:0] speed, position, home_pos, spd_prev;
  hseq_pkg::hseq_method_t method;
  int err_total = 0;
  int n_checks = 0;
  logic [5:0] hseq_rsv [7] = '{6'h00, 6'h0f, 6'h10, 6'h1f, 6'h20, 6'h24, 6'h3f};
  hseq_top #(.TICK_DIV(16'h0001)) hseq_top_inst (.core_clk_in(clk), .rst_b_in(rst_b),
    .switch_speed_in(SW_SPD), .zero_speed_in(ZR_SPD), .method_in(method),
    .accel_in(ACC), .home_pos_in(home_pos), .start_in(start), .pos_step_in(step),
    .index_in(idx), .home_sw_in(home), .pos_limit_in(plim), .neg_limit_in(nlim),
    .speed_out(speed), .dir_pos_out(dir_pos), .position_out(position),
    .busy_out(busy), .done_out(done), .error_out(error));
  hseq_motor_model hseq_motor_model_inst (.core_clk_in(clk), .rst_b_in(rst_b),
    .speed_in(speed), .dir_pos_in(dir_pos), .place_in(place), .step_out(step),
    .index_out(idx), .home_sw_out(home), .pos_limit_out(plim), .neg_limit_out(nlim));
  // ----------------------------------------
  // Checking and verdict
  // ----------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      err_total++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic print_verdict();
    $display("checks=%0d errors=%0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : print_verdict
  function automatic logic [1:0] exp_dir(input logic [5:0] m);
    case (m)
      1, 11, 12, 13, 14, 17, 27, 28, 29, 30, 33: return 2'h0;
      2, 3, 4, 5, 6, 7, 8, 9, 10, 18, 19, 20, 21, 22: return 2'h1;
      23, 24, 25, 26, 34: return 2'h1;
      default: return 2'h2;
    endcase
  endfunction : exp_dir
  // ----------------------------------------
  // Access tasks
  // ----------------------------------------
  task automatic kick(input logic [5:0] m);
    @(posedge clk) place <= 1'b1;
    @(posedge clk) place <= 1'b0;
    // Let the pin edges caused by the jump pass the synchronisers before start
    repeat (4) @(posedge clk);
    @(posedge clk)
    begin
      method <= m;
      home_pos <= 32'h1000_0000 + m;
      start <= 1'b1;
    end
    @(posedge clk) start <= 1'b0;
    #1;
  endtask : kick
  task automatic run_method(input logic [5:0] m, input bit poke);
    int n;
    kick(m);
    check(busy, 1'b1);
    for (n = 0; n < 200 && speed === 32'h0000_0000; n++)
      @(posedge clk) #1;
    if (exp_dir(m) != 2'h2)
      check(dir_pos, exp_dir(m));
    if (poke)
    begin
      @(posedge clk)
      begin
        method <= 6'h23;
        start <= 1'b1;
      end
      @(posedge clk) start <= 1'b0;
      repeat (3) @(posedge clk);
      #1 check({busy, done}, 2'h2);
    end
    for (n = 0; n < 20000 && done !== 1'b1; n++)
      @(posedge clk) #1;
    check({done, error, busy}, 3'h4);
    check(position, 32'h1000_0000 + m);
    check(speed, 32'h0000_0000);
  endtask : run_method
  // ----------------------------------------
  // Ramp never exceeds switch speed nor steps beyond one accel value
  // ----------------------------------------
  always @(negedge clk)
  begin
    if (rst_b === 1'b1)
    begin
      check({31'h0, speed <= SW_SPD}, 32'h1);
      check({31'h0, (speed - spd_prev <= ACC) || (spd_prev - speed <= ACC)}, 32'h1);
    end
    spd_prev = speed;
  end
  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  initial
  begin
    #600_000;
    err_total++;
    print_verdict();
  end
  initial
  begin
    rst_b = 1'b0;
    start = 1'b0;
    place = 1'b0;
    method = 6'h00;
    home_pos = 32'h0000_0000;
    spd_prev = 32'h0000_0000;
    repeat (2) @(posedge clk);
    #1 check(speed, 32'h0000_0000);
    check(position, 32'h0000_0000);
    check({dir_pos, busy, done, error}, 4'h8);
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    repeat (4) @(posedge clk);
    kick(6'h23);
    check({busy, done}, 2'h2);
    @(posedge clk) #1 check({done, busy}, 2'h2);
    check(position, 32'h1000_0023);
    check(speed, 32'h0000_0000);
    foreach (hseq_rsv[i])
    begin
      kick(hseq_rsv[i]);
      check({error, busy}, 2'h2);
      @(posedge clk) #1 check(error, 1'b1);
      check(speed, 32'h0000_0000);
    end
    for (int m = 1; m <= 34; m++)
      if (!(m inside {15, 16, 31, 32}))
        run_method(6'(m), m == 33);
    print_verdict();
  end
endmodule : hseq_tb_top
